/* logic/dscg_params.svh */
/*
 * Constants of the deep-sleep clock gating block: register offsets,
 * field positions, reset values and unit numbering.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef DSCG_PARAMS_SVH
`define DSCG_PARAMS_SVH

// Register byte offsets inside the block window
`define DSCG_ADR_W 12
`define DSCG_OFS_GATE 12'h124
`define DSCG_OFS_STAT 12'h200
`define DSCG_OFS_MASK 12'h204

// Field positions in the gating word
`define DSCG_BIT_ASYNC0 0
`define DSCG_BIT_ASYNC1 1
`define DSCG_BIT_SYNC0 4
`define DSCG_BIT_CTR0 16
`define DSCG_BIT_CTR1 17
`define DSCG_BIT_CTR2 18
`define DSCG_BIT_COMPARATOR0_GATE 24

// Writable bits and reset values
`define DSCG_WMASK 32'h0107_0013
`define DSCG_GATE_RST 32'h0000_0000
`define DSCG_WORD_ZERO 32'h0000_0000
`define DSCG_SEL_ALL 4'hf

// Unit numbering on the peripheral access port
`define DSCG_UNIT_W 3
`define DSCG_UNIT_LIMIT 3'h7

`endif

/* logic/dscg_pkg.sv */
/*
 * Types and field conversions of the deep-sleep clock gating block.
 * Assumes the constants header is on the include path.
 */
`include "dscg_params.svh"

package dscg_pkg;

    // One enable per gated unit, bit 0 is asynchronous serial 0
    typedef struct packed {
        logic comparator0_gate;
        logic gp_counter2_gate;
        logic gp_counter1_gate;
        logic gp_counter0_gate;
        logic sync_serial0_gate;
        logic async_serial1_gate;
        logic async_serial0_gate;
    } dscg_gate_t;

    // Power state of the system
    typedef enum logic [1:0] {DSCG_MODE_RUN, DSCG_MODE_SLEEP, DSCG_MODE_DEEP} dscg_mode_t;

    // Bus access aimed at one gated unit
    typedef struct packed {
        logic valid;
        logic write;
        logic [`DSCG_UNIT_W-1:0] unit;
    } dscg_req_t;

    // Gate fields placed at their register positions
    function automatic logic [31:0] gate_to_word(input dscg_gate_t g);
        logic [31:0] w;
        w = `DSCG_WORD_ZERO;
        w[`DSCG_BIT_ASYNC0] = g.async_serial0_gate;
        w[`DSCG_BIT_ASYNC1] = g.async_serial1_gate;
        w[`DSCG_BIT_SYNC0] = g.sync_serial0_gate;
        w[`DSCG_BIT_CTR0] = g.gp_counter0_gate;
        w[`DSCG_BIT_CTR1] = g.gp_counter1_gate;
        w[`DSCG_BIT_CTR2] = g.gp_counter2_gate;
        w[`DSCG_BIT_COMPARATOR0_GATE] = g.comparator0_gate;
        return w;
    endfunction

    // Register word back to gate fields
    function automatic dscg_gate_t word_to_gate(input logic [31:0] w);
        dscg_gate_t g;
        g.async_serial0_gate = w[`DSCG_BIT_ASYNC0];
        g.async_serial1_gate = w[`DSCG_BIT_ASYNC1];
        g.sync_serial0_gate = w[`DSCG_BIT_SYNC0];
        g.gp_counter0_gate = w[`DSCG_BIT_CTR0];
        g.gp_counter1_gate = w[`DSCG_BIT_CTR1];
        g.gp_counter2_gate = w[`DSCG_BIT_CTR2];
        g.comparator0_gate = w[`DSCG_BIT_COMPARATOR0_GATE];
        return g;
    endfunction

    // True when the addressed unit exists and has its clock
    function automatic logic unit_on(input dscg_gate_t en, input logic [`DSCG_UNIT_W-1:0] idx);
        logic [6:0] v;
        v = en;
        return (idx < `DSCG_UNIT_LIMIT) ? v[idx] : 1'b0;
    endfunction

endpackage

/* logic/dscg_gate_ctl.sv */
/*
 * Selects the active gating pattern for the current power state and
 * registers the unit clock enables.
 * Assumes the run and sleep patterns come from registers elsewhere.
 */
`timescale 1ns/100ps
`include "dscg_params.svh"

module dscg_gate_ctl
    import dscg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Power state and patterns
    input wire dscg_mode_t mode_i,
    input wire logic auto_clock_gating_i,
    input wire dscg_gate_t run_i,
    input wire dscg_gate_t sleep_i,
    input wire dscg_gate_t deep_i,
    // Registered enables
    output dscg_gate_t en_o
);

    dscg_gate_t next_en;

    // Without automatic gating the run pattern holds in all three legal states
    always_comb begin
        next_en = run_i;
        unique case (mode_i)
            DSCG_MODE_RUN: next_en = run_i;
            DSCG_MODE_SLEEP: next_en = auto_clock_gating_i ? sleep_i : run_i;
            DSCG_MODE_DEEP: next_en = auto_clock_gating_i ? deep_i : run_i; // [R4]
            default: next_en = '0;
        endcase
    end

    // Enables start off so nothing runs unasked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_o <= '0; // [R3]
        end else begin
            en_o <= next_en; // [R1]
        end
    end

    a_deep_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_i == DSCG_MODE_DEEP && auto_clock_gating_i) |=> en_o == $past(deep_i)) // [R4]
        else $error("deep-sleep pattern not applied");
    a_run_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_i == DSCG_MODE_RUN
            || (!auto_clock_gating_i && mode_i inside {DSCG_MODE_SLEEP, DSCG_MODE_DEEP}))
        |=> en_o == $past(run_i)) // [R4]
        else $error("run pattern not applied");
    // Illegal state code leaves every unit stopped
    a_bad_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        !(mode_i inside {DSCG_MODE_RUN, DSCG_MODE_SLEEP, DSCG_MODE_DEEP}) |=> en_o == '0)
        else $error("illegal state code left a unit clocked");
    a_reset_off: assert property (@(posedge clk_i)
        rst_i |=> en_o == '0) // [R3]
        else $error("enables not cleared by reset");
    c_deep_entry: cover property (@(posedge clk_i) disable iff (rst_i)
        mode_i == DSCG_MODE_RUN ##1 mode_i == DSCG_MODE_DEEP && auto_clock_gating_i);

endmodule

/* logic/dscg_fault_chk.sv */
/*
 * Judges each access aimed at a gated unit: done when the unit has its
 * clock, bus fault otherwise. Results are one-cycle pulses.
 * Assumes one request per cycle at most, held for one cycle only.
 */
`timescale 1ns/100ps
`include "dscg_params.svh"

module dscg_fault_chk
    import dscg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Access and current enables
    input wire dscg_req_t req_i,
    input wire dscg_gate_t en_i,
    // Registered results
    output logic done_o,
    output logic fault_o,
    output dscg_gate_t fault_units_o
);

    logic on;
    logic [6:0] hit;

    assign on = unit_on(en_i, req_i.unit);
    // One-hot unit; index seven matches no unit
    assign hit = (req_i.unit < `DSCG_UNIT_LIMIT) ? 7'h01 << req_i.unit : 7'h00;

    // Stopped units never answer normally
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            fault_o <= 1'b0;
            fault_units_o <= '0;
        end else begin
            done_o <= req_i.valid && on; // [R1]
            fault_o <= req_i.valid && !on; // [R2]
            fault_units_o <= (req_i.valid && !on) ? dscg_gate_t'(hit) : '0; // [R2]
        end
    end

    a_fault_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.valid && !unit_on(en_i, req_i.unit) |=> fault_o && !done_o) // [R2]
        else $error("access to stopped unit not faulted");
    a_done_clocked: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.valid && unit_on(en_i, req_i.unit) |=> done_o && !fault_o) // [R1]
        else $error("access to clocked unit faulted");
    a_fault_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_o |-> $past(req_i.valid) && fault_units_o != '0
            || $past(req_i.unit) == `DSCG_UNIT_LIMIT) // [R2]
        else $error("fault without a cause");
    c_fault_seen: cover property (@(posedge clk_i) disable iff (rst_i) fault_o);

endmodule

/* logic/dscg_top.sv */
/*
 * Deep-sleep clock gating bank: the software register that chooses which
 * peripheral units keep their clock in Deep-Sleep, the selection of the
 * active pattern per power state, bus fault detection for accesses to
 * stopped units, and a fault status register with mask and interrupt.
 * Assumes a classic Wishbone master on the system clock, power state and
 * the run and sleep patterns supplied by the surrounding system control.
 */
// Functional notes
// R1 - Each gating bit enables one unit clock
// R2 - Access to a stopped unit gives bus fault
// R3 - All gating bits reset to zero
// R4 - Deep-Sleep uses this pattern, others elsewhere
// R5 - Bits 16 to 18 gate counters 0-2
// R6 - Bit 4 gates synchronous serial unit 0
// R7 - Bits 0 and 1 gate asynchronous serials
// R8 - Reserved bits read zero, ignore writes
// R9 - Software preserves reserved bits on updates
// R10 - Software enables units it needs asleep
// R11 - Bit 24 gates analog comparator 0
`timescale 1ns/100ps
`include "dscg_params.svh"

module dscg_top
    import dscg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Power state and the other gating patterns
    input wire dscg_mode_t mode_i,
    input wire logic auto_clock_gating_i,
    input wire dscg_gate_t run_clock_gate_bank1_i,
    input wire dscg_gate_t sleep_clock_gate_bank1_i,
    // Accesses aimed at gated units
    input wire dscg_req_t periph_req_i,
    output logic periph_done_o,
    output logic periph_fault_o,
    // Unit clock enables
    output dscg_gate_t unit_clk_en_o,
    // Interrupt
    output logic irq_o
);

    // True when the address selects the given register word
    function automatic logic reg_hit(input logic [31:0] adr, input logic [11:0] ofs);
        return (adr[31:`DSCG_ADR_W] == '0) && (adr[`DSCG_ADR_W-1:2] == ofs[`DSCG_ADR_W-1:2]);
    endfunction

    logic [31:0] gate_word;
    logic [31:0] stat_word;
    logic [31:0] mask_word;
    logic [31:0] pend_word;
    logic [31:0] lane_mask;
    logic [31:0] wr_mask;
    logic [31:0] next_rd;
    logic [31:0] fault_set;
    logic [31:0] fault_clr;
    logic bus_req;
    logic bus_new;
    logic wr_go;
    logic hit_gate;
    logic hit_stat;
    logic hit_mask;
    dscg_gate_t fault_units;

    // Byte lanes widened into a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    // Decode of the request on the bus
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_new = bus_req && !wb_ack_o;
    assign hit_gate = reg_hit(wb_adr_i, `DSCG_OFS_GATE);
    assign hit_stat = reg_hit(wb_adr_i, `DSCG_OFS_STAT);
    assign hit_mask = reg_hit(wb_adr_i, `DSCG_OFS_MASK);

    // A write lands at the edge where the master sees ack
    assign wr_go = bus_req && wb_we_i && wb_ack_o;

    // Reserved positions can never be written
    assign wr_mask = lane_mask & `DSCG_WMASK; // [R8]

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_new;
        end
    end

    // Read multiplexer; unmapped words answer zero rather than stall
    always_comb begin
        next_rd = `DSCG_WORD_ZERO;
        if (hit_gate) begin
            next_rd = gate_word & `DSCG_WMASK; // [R8]
        end else if (hit_stat) begin
            next_rd = stat_word;
        end else if (hit_mask) begin
            next_rd = mask_word;
        end
    end

    // Read data captured with ack so it stands stable while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `DSCG_WORD_ZERO;
        end else if (bus_new && !wb_we_i) begin
            wb_dat_o <= next_rd;
        end else begin
            wb_dat_o <= `DSCG_WORD_ZERO;
        end
    end

    // Deep-Sleep gating word; only the unit enable bits are stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_word <= `DSCG_GATE_RST; // [R3]
        end else if (wr_go && hit_gate) begin
            // Counters, serials and comparator share one masked update
            gate_word <= (gate_word & ~wr_mask) | (wb_dat_i & wr_mask); // [R5] [R6] [R7] [R11]
        end
    end

    // Interrupt mask, same layout as the gating word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_word <= `DSCG_WORD_ZERO;
        end else if (wr_go && hit_mask) begin
            mask_word <= (mask_word & ~wr_mask) | (wb_dat_i & wr_mask);
        end
    end

    // Fault events per unit, write one to clear
    assign fault_set = gate_to_word(fault_units);
    assign fault_clr = (wr_go && hit_stat) ? (wb_dat_i & wr_mask) : `DSCG_WORD_ZERO;

    // A fault in the clearing cycle survives: set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_word <= `DSCG_WORD_ZERO;
        end else begin
            stat_word <= (stat_word & ~fault_clr) | fault_set; // [R2]
        end
    end

    // Level interrupt, one cycle behind the status to keep it a flop
    assign pend_word = stat_word & mask_word;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |pend_word;
        end
    end

    // Pattern selection per power state
    dscg_gate_ctl u_gate_ctl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode_i),
        .auto_clock_gating_i(auto_clock_gating_i),
        .run_i(run_clock_gate_bank1_i),
        .sleep_i(sleep_clock_gate_bank1_i),
        .deep_i(word_to_gate(gate_word)), // [R4]
        .en_o(unit_clk_en_o)
    );

    // Access checking against the enables actually in force
    dscg_fault_chk u_fault_chk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(periph_req_i),
        .en_i(unit_clk_en_o), // [R2]
        .done_o(periph_done_o),
        .fault_o(periph_fault_o),
        .fault_units_o(fault_units)
    );

    // Reset leaves every unit unclocked
    a_gate_reset: assert property (@(posedge clk_i)
        rst_i |=> gate_word == `DSCG_GATE_RST) // [R3]
        else $error("gating word not zero after reset");

    // Reserved positions of the stored word stay zero
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (gate_word & ~`DSCG_WMASK) == `DSCG_WORD_ZERO) // [R8]
        else $error("reserved gating bit set");

    // A full write stores exactly the enable bits
    a_wr_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && hit_gate && wb_sel_i == `DSCG_SEL_ALL
        |=> gate_word == ($past(wb_dat_i) & `DSCG_WMASK)) // [R5] [R6] [R7] [R11]
        else $error("gating write not stored");

    // Counter enables follow bits 16 to 18 of a write
    a_ctr_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && hit_gate && wb_sel_i[2]
        |=> gate_word[`DSCG_BIT_CTR2:`DSCG_BIT_CTR0]
            == $past(wb_dat_i[`DSCG_BIT_CTR2:`DSCG_BIT_CTR0])) // [R5]
        else $error("counter gating bits wrong");

    // Comparator enable follows bit 24 of a write
    a_cmp_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && hit_gate && wb_sel_i[3]
        |=> gate_word[`DSCG_BIT_COMPARATOR0_GATE] == $past(wb_dat_i[`DSCG_BIT_COMPARATOR0_GATE])) // [R11]
        else $error("comparator gating bit wrong");

    // Serial enables follow bits 0, 1 and 4 of a write
    a_serial_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && hit_gate && wb_sel_i[0]
        |=> gate_word[`DSCG_BIT_SYNC0] == $past(wb_dat_i[`DSCG_BIT_SYNC0])
            && gate_word[`DSCG_BIT_ASYNC1:`DSCG_BIT_ASYNC0]
            == $past(wb_dat_i[`DSCG_BIT_ASYNC1:`DSCG_BIT_ASYNC0])) // [R6] [R7]
        else $error("serial gating bits wrong");

    // A read returns the stored word, reserved bits zero
    a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_new && !wb_we_i && hit_gate
        |=> wb_ack_o && wb_dat_o == $past(gate_word) && (wb_dat_o & ~`DSCG_WMASK) == '0) // [R8]
        else $error("gating read back wrong");

    // A stored enable reaches the unit one cycle later in Deep-Sleep
    a_deep_reach: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_i == DSCG_MODE_DEEP && auto_clock_gating_i)[*2]
        |-> unit_clk_en_o == word_to_gate($past(gate_word))) // [R1] [R4]
        else $error("unit enable does not follow gating word");

    // Ack is a single-cycle answer
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // A fault event lands in the status word
    a_fault_status: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_set != '0 |=> (stat_word & $past(fault_set)) == $past(fault_set)) // [R2]
        else $error("fault event lost");

    // Interrupt tracks pending unmasked status
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == (|$past(pend_word)))
        else $error("interrupt level wrong");

    // Every new request is answered in the next cycle
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_new |=> wb_ack_o)
        else $error("request not acknowledged");

    // Read data rests at zero outside the ack cycle
    a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == `DSCG_WORD_ZERO)
        else $error("read data not zero outside ack");

    // Mask keeps its unused positions at zero
    a_mask_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_word & ~`DSCG_WMASK) == `DSCG_WORD_ZERO)
        else $error("unused mask bit set");

    // Status only ever holds unit positions
    a_stat_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
        (stat_word & ~`DSCG_WMASK) == `DSCG_WORD_ZERO)
        else $error("unused status bit set");

    // Write one clears a status bit when no fault races it
    a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && hit_stat && fault_set == `DSCG_WORD_ZERO
        |=> (stat_word & $past(fault_clr)) == `DSCG_WORD_ZERO)
        else $error("status bit not cleared");

    // Writes elsewhere leave the gating word alone
    a_gate_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_go && hit_gate) |=> gate_word == $past(gate_word))
        else $error("gating word changed without a write");

    c_gate_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_go && hit_gate);
    c_irq_raise: cover property (@(posedge clk_i) disable iff (rst_i) !irq_o ##1 irq_o);
    c_clear_race: cover property (@(posedge clk_i) disable iff (rst_i)
        fault_set != '0 && fault_clr != '0);

endmodule

/* verification/test_deep_sleep_clock_gating_bank1.sv */
/*
 * Self-checking bench of the deep-sleep clock gating bank: register
 * access over classic Wishbone, pattern selection per power state,
 * bus faults for stopped units, fault status, mask and interrupt.
 * Assumes the design files are compiled first and the header is on the path.
 */
`timescale 1ns/100ps
`include "dscg_params.svh"

module test_deep_sleep_clock_gating_bank1
    import dscg_pkg::*;
;
    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [31:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    dscg_mode_t mode_i;
    logic auto_clock_gating_i;
    dscg_gate_t run_clock_gate_bank1_i;
    dscg_gate_t sleep_clock_gate_bank1_i;
    dscg_req_t periph_req_i;
    logic periph_done_o;
    logic periph_fault_o;
    dscg_gate_t unit_clk_en_o;
    logic irq_o;
    int n_mismatch;
    int samples_checked;
    int cycles;
    logic [31:0] rnd;
    logic [31:0] rd_q[$];
    logic [1:0] pr_q[$];
    // Gating word bit of each unit index
    localparam int POS [7] = '{0, 1, 4, 16, 17, 18, 24};

    dscg_top dscg_top_inst (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mode_i(mode_i), .auto_clock_gating_i(auto_clock_gating_i),
        .run_clock_gate_bank1_i(run_clock_gate_bank1_i),
        .sleep_clock_gate_bank1_i(sleep_clock_gate_bank1_i),
        .periph_req_i(periph_req_i), .periph_done_o(periph_done_o),
        .periph_fault_o(periph_fault_o), .unit_clk_en_o(unit_clk_en_o),
        .irq_o(irq_o)
    );

    // 50 MHz system clock
    always #10 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction

    // Own mapping from word to enables, kept apart from the package
    function automatic dscg_gate_t exp_en(input logic [31:0] w);
        dscg_gate_t g;
        for (int u = 0; u < 7; u++) begin
            g[u] = w[POS[u]];
        end
        return g;
    endfunction

    task automatic report(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        report(e, g);
    endtask

    task automatic cmp_gate(input dscg_gate_t e, input dscg_gate_t g);
        report({25'h0, e}, {25'h0, g});
    endtask

    task automatic cmp_bits(input logic [1:0] e, input logic [1:0] g);
        report({30'h0, e}, {30'h0, g});
    endtask

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    task automatic wb_write(input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        wb_xfer(1'h1, adr, sel, dat);
    endtask

    // Expected data goes to the monitor before the cycle starts
    task automatic wb_read(input logic [31:0] adr, input logic [31:0] e);
        rd_q.push_back(e);
        wb_xfer(1'h0, adr, 4'hf, rnd);
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        #1;
    endtask

    // Read data monitor
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
            if (rd_q.size() == 0) n_mismatch++;
            else cmp_word(rd_q.pop_front(), wb_dat_o);
        end
    end

    // Peripheral access result monitor
    always @(posedge clk_i) begin
        if (periph_done_o === 1'h1 || periph_fault_o === 1'h1) begin
            if (pr_q.size() == 0) n_mismatch++;
            else cmp_bits(pr_q.pop_front(), {periph_done_o, periph_fault_o});
        end
    end

    // Hang guard, well above the two hundred or so cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] g;
        logic [31:0] st;
        dscg_gate_t e;
        logic on;
        clk_i = 1'h0;
        rst_i = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 32'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        mode_i = DSCG_MODE_DEEP;
        auto_clock_gating_i = 1'h1;
        run_clock_gate_bank1_i = 7'h0;
        sleep_clock_gate_bank1_i = 7'h0;
        periph_req_i = 5'h0;
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        rnd = 32'h62a5_93c2;
        st = 32'h0;
        do_reset();
        cmp_gate(7'h0, unit_clk_en_o);
        cmp_bits(2'h0, {1'h0, irq_o});
        wb_read(`DSCG_OFS_GATE, `DSCG_GATE_RST);
        wb_read(`DSCG_OFS_STAT, 32'h0);
        wb_read(`DSCG_OFS_MASK, 32'h0);
        // Writable bits only, then lane by lane clears
        wb_write(`DSCG_OFS_GATE, 32'hffff_ffff, 4'hf);
        wb_read(`DSCG_OFS_GATE, 32'h0107_0013);
        wb_write(`DSCG_OFS_GATE, 32'h0, 4'h1);
        wb_read(`DSCG_OFS_GATE, 32'h0107_0000);
        wb_write(`DSCG_OFS_GATE, 32'h0, 4'h4);
        wb_read(`DSCG_OFS_GATE, 32'h0100_0000);
        // Unmapped places read zero and leave the word alone
        wb_write(32'h0000_0300, 32'hffff_ffff, 4'hf);
        wb_read(32'h0000_0300, 32'h0);
        wb_read(32'h0000_1124, 32'h0);
        wb_read(`DSCG_OFS_GATE, 32'h0100_0000);
        // Read-modify-write keeps the reserved bits as read
        wb_write(`DSCG_OFS_GATE, 32'h0100_0000 | 32'h0000_0010, 4'hf);
        wb_read(`DSCG_OFS_GATE, 32'h0100_0010);
        // Every mode code with auto gating low and high
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 2; a++) begin
                rnd = lfsr(rnd);
                @(posedge clk_i);
                mode_i <= dscg_mode_t'(m[1:0]);
                auto_clock_gating_i <= a[0];
                run_clock_gate_bank1_i <= rnd[6:0];
                sleep_clock_gate_bank1_i <= rnd[13:7];
                if (m == 3) e = 7'h0;
                else if (a == 0 || m == 0) e = rnd[6:0];
                else if (m == 1) e = rnd[13:7];
                else e = exp_en(32'h0100_0010);
                repeat (2) @(posedge clk_i);
                #1 cmp_gate(e, unit_clk_en_o);
            end
        end
        @(posedge clk_i);
        mode_i <= DSCG_MODE_DEEP;
        auto_clock_gating_i <= 1'h1;
        // Back-to-back accesses to all units, one unit surely stopped
        for (int it = 0; it < 3; it++) begin
            rnd = lfsr(rnd);
            g = rnd & ~(32'h1 << POS[it]);
            wb_write(`DSCG_OFS_GATE, g, 4'hf);
            wb_read(`DSCG_OFS_GATE, g & 32'h0107_0013);
            repeat (2) @(posedge clk_i);
            #1 cmp_gate(exp_en(g), unit_clk_en_o);
            for (int u = 0; u < 8; u++) begin
                @(posedge clk_i);
                periph_req_i <= {1'h1, rnd[u], u[2:0]};
                on = (u < 7) ? g[POS[u]] : 1'h0;
                pr_q.push_back({on, ~on});
                if (!on && u < 7) st = st | (32'h1 << POS[u]);
            end
            @(posedge clk_i);
            periph_req_i <= 5'h0;
        end
        // Sticky status, mask, interrupt level and write-one clear
        wb_read(`DSCG_OFS_STAT, st);
        cmp_bits(2'h0, {1'h0, irq_o});
        wb_write(`DSCG_OFS_MASK, 32'hffff_ffff, 4'hf);
        wb_read(`DSCG_OFS_MASK, 32'h0107_0013);
        repeat (2) @(posedge clk_i);
        #1 cmp_bits(2'h1, {1'h0, irq_o});
        wb_write(`DSCG_OFS_STAT, st, 4'hf);
        wb_read(`DSCG_OFS_STAT, 32'h0);
        repeat (2) @(posedge clk_i);
        #1 cmp_bits(2'h0, {1'h0, irq_o});
        // Second reset in mid-run clears the word again
        wb_write(`DSCG_OFS_GATE, 32'hffff_ffff, 4'hf);
        do_reset();
        cmp_gate(7'h0, unit_clk_en_o);
        wb_read(`DSCG_OFS_GATE, 32'h0);
        wb_read(`DSCG_OFS_MASK, 32'h0);
        repeat (4) @(posedge clk_i);
        if (rd_q.size() != 0 || pr_q.size() != 0) n_mismatch++;
        end_of_test();
    end
endmodule
